/* core/acr_regs.sv */
// accel configuration and status register bank behind a serial bus target
`include "acr_defs.svh"
module acr_regs
   import acr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `ACR_I2C_ADDR_RST
) (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        z_valid_i,
   input  wire logic [11:0] z_filt_i,
   input  wire logic [11:0] z_unfilt_i,
   input  wire logic        sig_motion_i,
   input  wire logic        slope_i,
   input  wire logic [2:0]  slope_axis_i,
   input  wire logic [2:0]  slope_neg_i,
   output acr_span_t        span_o,
   output logic [2:0]       bw_step_o,
   output logic             suspend_o,
   output logic             reduced_power_enable_o,
   output logic [3:0]       doze_duration_code_o,
   output logic             unfiltered_o,
   output logic [2:0]       slope_irq_enable_o,
   output logic             fresh_sample_irq_enable_o
);
   ////////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic acr_span_t span_dec(input logic [3:0] c);
      case (c)
         `ACR_SPAN_2G: span_dec = ACR_SPAN_2G;                 // [R7]
         `ACR_SPAN_4G: span_dec = ACR_SPAN_4G;
         `ACR_SPAN_8G: span_dec = ACR_SPAN_8G;
         default:      span_dec = ACR_SPAN_UNDEF;
      endcase
   endfunction

   // step 0 is 7.81 Hz, each step doubles, step 7 is 1000 Hz
   function automatic logic [2:0] bw_dec(input logic [4:0] c);
      if (c[4]) begin
         bw_dec = 3'h7;                                        // [R8]
      end else if (c <= `ACR_BW_FLOOR) begin
         bw_dec = 3'h0;                                        // [R8]
      end else begin
         bw_dec = c[2:0];                                      // [R8]
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus target and sample path
   logic        rd_stb, wr_stb, soft_rst;
   logic [7:0]  rd_addr, wr_addr, wr_data, rd_data;
   logic [11:0] z_val;
   logic        z_fresh, z_locked;
   logic        sda_o_r;

   logic [3:0]  span_r, span_nxt;
   logic [4:0]  bw_r, bw_nxt;
   logic [7:0]  pwr_r, pwr_nxt;
   logic [1:0]  setup_r, setup_nxt;
   logic [2:0]  slope_en_r, slope_en_nxt;
   logic        fresh_en_r, fresh_en_nxt;
   logic        sig_sts_r, sig_sts_nxt, slope_sts_r, slope_sts_nxt;
   logic        fresh_sts_r, fresh_sts_nxt;
   logic [2:0]  cause_r, cause_nxt, sign_r, sign_nxt;
   logic        slope_hit;
   acr_span_t   span_q_r;
   logic [2:0]  bw_q_r;

   acr_i2c_target #(
      .DEV_ADDR(DEV_ADDR)
   ) u_target (
      .ref_clk_i(ref_clk_i),
      .resetn_i (resetn_i),
      .scl_i    (scl_i),
      .sda_i    (sda_i),
      .sda_oe_o (sda_oe_o),
      .rd_stb_o (rd_stb),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .wr_stb_o (wr_stb),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data)
   );

   // protection is on while the guard-disable bit is clear
   acr_sample_guard u_guard (
      .ref_clk_i   (ref_clk_i),
      .resetn_i    (resetn_i),
      .soft_rst_i  (soft_rst),
      .guard_en_i  (~setup_r[0]),                              // [R12]
      .sample_stb_i(z_valid_i),
      .sample_i    (setup_r[1] ? z_unfilt_i : z_filt_i),       // [R13]
      .lo_rd_i     (rd_stb && rd_addr == `ACR_OFS_Z_LO),
      .hi_rd_i     (rd_stb && rd_addr == `ACR_OFS_Z_HI),
      .z_o         (z_val),
      .fresh_o     (z_fresh),
      .locked_o    (z_locked)
   );

   assign soft_rst  = wr_stb && wr_addr == `ACR_OFS_SOFTWARE_RESET_TRIGGER && wr_data == `ACR_SOFTWARE_RESET_TRIGGER_KEY; // [R14]
   assign slope_hit = slope_i && |(slope_axis_i & slope_en_r);  // [R15]

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped and write-only offsets read zero
   always_comb begin
      case (rd_addr)
         `ACR_OFS_Z_LO:       rd_data = {z_val[3:0], 3'b000, z_fresh};          // [R1]
         `ACR_OFS_Z_HI:       rd_data = z_val[11:4];                            // [R1]
         `ACR_OFS_MOT_STS:    rd_data = {5'h00, slope_sts_r, 1'b0, sig_sts_r};  // [R2] [R3]
         `ACR_OFS_FRESH_STS:  rd_data = {fresh_sts_r, 7'h00};                   // [R4]
         `ACR_OFS_SLOPE_INFO: rd_data = {1'b0, sign_r, 1'b0, cause_r};          // [R5] [R6]
         `ACR_OFS_SPAN:       rd_data = {4'h0, span_r};                         // [R18]
         `ACR_OFS_BW:         rd_data = {3'h0, bw_r};
         `ACR_OFS_PWR:        rd_data = pwr_r;
         `ACR_OFS_SETUP:      rd_data = {setup_r, 6'h00};
         `ACR_OFS_SLOPE_EN:   rd_data = {5'h00, slope_en_r};
         `ACR_OFS_FRESH_EN:   rd_data = {3'h0, fresh_en_r, 4'h0};
         default:             rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration writes, masked to writable fields
   always_comb begin
      span_nxt     = span_r;
      bw_nxt       = bw_r;
      pwr_nxt      = pwr_r;
      setup_nxt    = setup_r;
      slope_en_nxt = slope_en_r;
      fresh_en_nxt = fresh_en_r;
      if (wr_stb) begin
         case (wr_addr)
            `ACR_OFS_SPAN:     span_nxt     = wr_data[3:0];                     // [R7]
            `ACR_OFS_BW:       bw_nxt       = wr_data[4:0];                     // [R8]
            `ACR_OFS_PWR:      pwr_nxt      = wr_data & 8'hDE;                  // [R9] [R10] [R11] [R18]
            `ACR_OFS_SETUP:    setup_nxt    = wr_data[7:6];                     // [R12] [R13]
            `ACR_OFS_SLOPE_EN: slope_en_nxt = wr_data[2:0];                     // [R15]
            `ACR_OFS_FRESH_EN: fresh_en_nxt = wr_data[`ACR_BIT_FRESH_EN];       // [R16]
            default:           span_nxt     = span_r;                           // [R18]
         endcase
      end
      if (soft_rst) begin
         span_nxt     = `ACR_SPAN_RST;                                          // [R14]
         bw_nxt       = `ACR_BW_RST;
         pwr_nxt      = 8'h00;
         setup_nxt    = 2'b00;
         slope_en_nxt = 3'b000;
         fresh_en_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event status: set by events, flags cleared by reading, cause and sign held until the next slope event or soft reset, set wins
   always_comb begin
      sig_sts_nxt   = sig_sts_r;
      slope_sts_nxt = slope_sts_r;
      fresh_sts_nxt = fresh_sts_r;
      cause_nxt     = cause_r;
      sign_nxt      = sign_r;
      if (rd_stb && rd_addr == `ACR_OFS_MOT_STS) begin
         sig_sts_nxt   = 1'b0;
         slope_sts_nxt = 1'b0;
      end
      if (rd_stb && rd_addr == `ACR_OFS_FRESH_STS) begin
         fresh_sts_nxt = 1'b0;
      end
      if (sig_motion_i) begin
         sig_sts_nxt = 1'b1;                                                    // [R2]
      end
      if (slope_hit) begin
         slope_sts_nxt = 1'b1;                                                  // [R3]
         cause_nxt     = slope_axis_i & slope_en_r;                             // [R5]
         sign_nxt      = slope_neg_i & slope_axis_i & slope_en_r;               // [R6]
      end
      if (z_valid_i && fresh_en_r) begin
         fresh_sts_nxt = 1'b1;                                                  // [R4] [R16]
      end
      if (soft_rst) begin
         sig_sts_nxt   = 1'b0;                                                  // [R14]
         slope_sts_nxt = 1'b0;
         fresh_sts_nxt = 1'b0;
         cause_nxt     = 3'b000;
         sign_nxt      = 3'b000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         span_r      <= `ACR_SPAN_RST;
         bw_r        <= `ACR_BW_RST;
         pwr_r       <= 8'h00;
         setup_r     <= 2'b00;
         slope_en_r  <= 3'b000;
         fresh_en_r  <= 1'b0;
         sig_sts_r   <= 1'b0;
         slope_sts_r <= 1'b0;
         fresh_sts_r <= 1'b0;
         cause_r     <= 3'b000;
         sign_r      <= 3'b000;
         span_q_r    <= ACR_SPAN_2G;
         bw_q_r      <= 3'h7;
         sda_o_r     <= 1'b0;
      end else begin
         span_r      <= span_nxt;
         bw_r        <= bw_nxt;
         pwr_r       <= pwr_nxt;
         setup_r     <= setup_nxt;
         slope_en_r  <= slope_en_nxt;
         fresh_en_r  <= fresh_en_nxt;
         sig_sts_r   <= sig_sts_nxt;
         slope_sts_r <= slope_sts_nxt;
         fresh_sts_r <= fresh_sts_nxt;
         cause_r     <= cause_nxt;
         sign_r      <= sign_nxt;
         span_q_r    <= span_dec(span_nxt);                                     // [R7]
         bw_q_r      <= bw_dec(bw_nxt);                                         // [R8]
         sda_o_r     <= 1'b0;    // open drain: only ever pulls low
      end
   end

   assign sda_o                     = sda_o_r;
   assign span_o                    = span_q_r;
   assign bw_step_o                 = bw_q_r;
   assign suspend_o                 = pwr_r[`ACR_BIT_SUSPEND];                  // [R9]
   assign reduced_power_enable_o    = pwr_r[`ACR_BIT_LOWPWR];                   // [R10]
   assign doze_duration_code_o      = pwr_r[4:1];                               // [R11]
   assign unfiltered_o              = setup_r[1];                               // [R13]
   assign slope_irq_enable_o        = slope_en_r;                               // [R15]
   assign fresh_sample_irq_enable_o = fresh_en_r;                               // [R16]

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_software_reset_trigger_clears_span: assert property (soft_rst |=> span_r == `ACR_SPAN_RST  // [R14]
                                         && bw_r == `ACR_BW_RST)
      else $error("soft reset did not restore span and bandwidth");
   a_sig_motion_sets: assert property (sig_motion_i && !soft_rst  // [R2]
                                       |=> rd_data_chk(`ACR_OFS_MOT_STS, 0))
      else $error("significant motion flag not set");
   a_slope_sets: assert property (slope_hit && !soft_rst |=> slope_sts_r && cause_r != 3'b000)  // [R3]
      else $error("slope event not recorded");
   a_slope_gated: assert property (slope_i && !(|(slope_axis_i & slope_en_r)) && !slope_sts_r
                                   && !soft_rst |=> !slope_sts_r)  // [R15]
      else $error("disabled axis raised slope status");
   a_slope_sign: assert property (slope_hit && !soft_rst  // [R6]
                                  |=> sign_r == $past(slope_neg_i & slope_axis_i & slope_en_r))
      else $error("slope sign mismatch");
   a_fresh_gated: assert property (z_valid_i && !fresh_en_r && !fresh_sts_r  // [R16]
                                   |=> !fresh_sts_r)
      else $error("new data status set while disabled");
   // decoded step is registered from the next field value, so it matches in the same cycle
   a_bw_decode: assert property (bw_r[4] |-> bw_step_o == 3'h7)  // [R8]
      else $error("bandwidth top codes not 1000 Hz");
   a_hold_high: assert property (z_locked && z_valid_i && !soft_rst && !setup_r[0]  // [R17]
                                 && !(rd_stb && rd_addr == `ACR_OFS_Z_HI)
                                 |=> z_val[11:4] == $past(z_val[11:4]))
      else $error("high byte changed while protected");
   a_reserved_zero: assert property (rd_addr == `ACR_OFS_SOFTWARE_RESET_TRIGGER |-> rd_data == 8'h00)  // [R18]
      else $error("write-only register read nonzero");
   a_suspend_follows: assert property (wr_stb && wr_addr == `ACR_OFS_PWR && !soft_rst  // [R9]
                                       |=> suspend_o == $past(wr_data[7])
                                       ##1 $stable(suspend_o) [*1])
      else $error("suspend bit did not follow write");

   function automatic logic rd_data_chk(input logic [7:0] a, input int b);
      rd_data_chk = (a == `ACR_OFS_MOT_STS) && sig_sts_r && (b == 0);
   endfunction

   c_soft_reset: cover property (soft_rst);
   c_slope_event: cover property (slope_hit);
   c_locked_sample: cover property (z_locked && z_valid_i);
   c_fresh_read: cover property (fresh_sts_r && rd_stb && rd_addr == `ACR_OFS_FRESH_STS);
endmodule

/* pkg/acr_defs.svh */
// register offsets, field positions and reset values of the accel register bank
// Notes on behaviour
// R1 - z sample split over two bytes, flag
// R2 - significant motion status at bit 0
// R3 - slope detection status at bit 2
// R4 - new data status at bit 7
// R5 - slope cause axis bits 0..2
// R6 - slope sign bits 4..6, 1 negative
// R7 - span code decode, reset 0011
// R8 - bandwidth code decode, reset 11111
// R9 - suspend bit 7, reset 0
// R10 - low power bit 6, reset 0
// R11 - doze duration bits 4:1, reset 0
// R12 - protection on while guard-disable bit 6 clear
// R13 - bit 7 selects unfiltered output data
// R14 - writing B6 resets every register
// R15 - per-axis slope interrupt enables, reset 0
// R16 - new data interrupt enable bit 4
// R17 - high byte held after low read
// R18 - read-only writes ignored, reserved reads zero
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_OFS_Z_LO        8'h06
`define ACR_OFS_Z_HI        8'h07
`define ACR_OFS_MOT_STS     8'h09
`define ACR_OFS_FRESH_STS   8'h0A
`define ACR_OFS_SLOPE_INFO  8'h0B
`define ACR_OFS_SPAN        8'h0F
`define ACR_OFS_BW          8'h10
`define ACR_OFS_PWR         8'h11
`define ACR_OFS_SETUP       8'h13
`define ACR_OFS_SOFTWARE_RESET_TRIGGER       8'h14
`define ACR_OFS_SLOPE_EN    8'h16
`define ACR_OFS_FRESH_EN    8'h17
`define ACR_SOFTWARE_RESET_TRIGGER_KEY       8'hB6
`define ACR_SPAN_RST        4'h3
`define ACR_SPAN_2G         4'h3
`define ACR_SPAN_4G         4'h5
`define ACR_SPAN_8G         4'h8
`define ACR_BW_RST          5'h1F
`define ACR_BW_FLOOR        5'h08
`define ACR_BIT_SIG_MOT     0
`define ACR_BIT_SLOPE       2
`define ACR_BIT_FRESH       7
`define ACR_BIT_SUSPEND     7
`define ACR_BIT_LOWPWR      6
`define ACR_BIT_GUARD_DIS   6
`define ACR_BIT_UNFILT      7
`define ACR_BIT_FRESH_EN    4
`define ACR_I2C_ADDR_RST    7'h18
`endif

/* pkg/acr_pkg.sv */
// types of the accel register bank
package acr_pkg;
   typedef enum logic [2:0] {
      ACR_I2C_IDLE,
      ACR_I2C_ADDR,
      ACR_I2C_ACK_A,
      ACR_I2C_WRX,
      ACR_I2C_ACK_W,
      ACR_I2C_TX,
      ACR_I2C_ACK_R
   } acr_i2c_state_t;
   typedef enum logic [1:0] {
      ACR_SPAN_2G,
      ACR_SPAN_4G,
      ACR_SPAN_8G,
      ACR_SPAN_UNDEF
   } acr_span_t;
endpackage

/* core/acr_i2c_target.sv */
// serial bus target: byte pointer, auto-increment, register strobes
`include "acr_defs.svh"
module acr_i2c_target
   import acr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `ACR_I2C_ADDR_RST
) (
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_oe_o,
   output logic            rd_stb_o,
   output logic [7:0]      rd_addr_o,
   input  wire logic [7:0] rd_data_i,
   output logic            wr_stb_o,
   output logic [7:0]      wr_addr_o,
   output logic [7:0]      wr_data_o
);
   acr_i2c_state_t st_r, st_nxt;
   logic       scl_r, sda_r, oe_r, oe_nxt, rw_r, rw_nxt, first_r, first_nxt;
   logic       nack_r, nack_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
   logic       start, stop, rise, fall;

   assign start    = scl_r & scl_i & sda_r & ~sda_i;
   assign stop     = scl_r & scl_i & ~sda_r & sda_i;
   assign rise     = ~scl_r & scl_i;
   assign fall     = scl_r & ~scl_i;
   assign sda_oe_o = oe_r;

   always_comb begin
      st_nxt    = st_r;
      oe_nxt    = oe_r;
      rw_nxt    = rw_r;
      first_nxt = first_r;
      nack_nxt  = nack_r;
      cnt_nxt   = cnt_r;
      sh_nxt    = sh_r;
      ptr_nxt   = ptr_r;
      rd_stb_o  = 1'b0;
      wr_stb_o  = 1'b0;
      rd_addr_o = ptr_r;
      wr_addr_o = ptr_r;
      wr_data_o = sh_r;
      if (start) begin
         st_nxt  = ACR_I2C_ADDR;
         cnt_nxt = 4'h0;
         oe_nxt  = 1'b0;
      end else if (stop) begin
         st_nxt = ACR_I2C_IDLE;
         oe_nxt = 1'b0;
      end else begin
         case (st_r)
            ACR_I2C_ADDR, ACR_I2C_WRX: begin
               if (rise && cnt_r != 4'h8) begin
                  sh_nxt  = {sh_r[6:0], sda_i};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (fall && cnt_r == 4'h8) begin
                  cnt_nxt = 4'h0;
                  if (st_r == ACR_I2C_ADDR) begin
                     if (sh_r[7:1] == DEV_ADDR) begin
                        oe_nxt    = 1'b1;
                        rw_nxt    = sh_r[0];
                        first_nxt = 1'b1;
                        st_nxt    = ACR_I2C_ACK_A;
                     end else begin
                        st_nxt = ACR_I2C_IDLE;
                     end
                  end else begin
                     oe_nxt = 1'b1;
                     st_nxt = ACR_I2C_ACK_W;
                     if (first_r) begin
                        ptr_nxt   = sh_r;
                        first_nxt = 1'b0;
                     end else begin
                        wr_stb_o = 1'b1;
                        ptr_nxt  = ptr_r + 8'h01;
                     end
                  end
               end
            end
            ACR_I2C_ACK_W: begin
               if (fall) begin
                  oe_nxt = 1'b0;
                  st_nxt = ACR_I2C_WRX;
               end
            end
            ACR_I2C_ACK_A, ACR_I2C_ACK_R: begin
               if (rise && st_r == ACR_I2C_ACK_R) begin
                  nack_nxt = sda_i;
               end
               if (fall) begin
                  cnt_nxt = 4'h0;
                  if (st_r == ACR_I2C_ACK_A && !rw_r) begin
                     oe_nxt = 1'b0;
                     st_nxt = ACR_I2C_WRX;
                  end else if (st_r == ACR_I2C_ACK_R && nack_r) begin
                     st_nxt = ACR_I2C_IDLE;
                  end else begin
                     // byte is fetched on the falling edge so the read side effect fires once
                     rd_stb_o = 1'b1;
                     ptr_nxt  = ptr_r + 8'h01;
                     sh_nxt   = rd_data_i;
                     oe_nxt   = ~rd_data_i[7];
                     st_nxt   = ACR_I2C_TX;
                  end
               end
            end
            ACR_I2C_TX: begin
               if (fall) begin
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == 4'h7) begin
                     oe_nxt = 1'b0;
                     st_nxt = ACR_I2C_ACK_R;
                  end else begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     oe_nxt = ~sh_r[6];
                  end
               end
            end
            default: st_nxt = ACR_I2C_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r    <= ACR_I2C_IDLE;
         scl_r   <= 1'b1;
         sda_r   <= 1'b1;
         oe_r    <= 1'b0;
         rw_r    <= 1'b0;
         first_r <= 1'b0;
         nack_r  <= 1'b0;
         cnt_r   <= 4'h0;
         sh_r    <= 8'h00;
         ptr_r   <= 8'h00;
      end else begin
         st_r    <= st_nxt;
         scl_r   <= scl_i;
         sda_r   <= sda_i;
         oe_r    <= oe_nxt;
         rw_r    <= rw_nxt;
         first_r <= first_nxt;
         nack_r  <= nack_nxt;
         cnt_r   <= cnt_nxt;
         sh_r    <= sh_nxt;
         ptr_r   <= ptr_nxt;
      end
   end
endmodule

/* core/acr_sample_guard.sv */
// z sample holding with read pairing protection
module acr_sample_guard (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        soft_rst_i,
   input  wire logic        guard_en_i,
   input  wire logic        sample_stb_i,
   input  wire logic [11:0] sample_i,
   input  wire logic        lo_rd_i,
   input  wire logic        hi_rd_i,
   output logic [11:0]      z_o,
   output logic             fresh_o,
   output logic             locked_o
);
   logic [11:0] z_r, z_nxt;
   logic [7:0]  pend_r, pend_nxt;
   logic        fresh_r, fresh_nxt, lock_r, lock_nxt;

   always_comb begin
      z_nxt     = z_r;
      pend_nxt  = pend_r;
      fresh_nxt = fresh_r;
      lock_nxt  = lock_r;
      if (lo_rd_i && guard_en_i) begin
         lock_nxt = 1'b1;                                  // [R17]
      end
      if (hi_rd_i || !guard_en_i) begin
         lock_nxt  = 1'b0;                                 // [R17]
         fresh_nxt = 1'b0;
      end
      if (sample_stb_i) begin
         z_nxt[3:0] = sample_i[3:0];
         pend_nxt   = sample_i[11:4];
         fresh_nxt  = 1'b1;                                // set wins over clear [R1]
      end
      // newest high byte waits here while locked, so unlock shows the latest sample
      if (!lock_nxt) begin
         z_nxt[11:4] = pend_nxt;                           // [R17]
      end
      if (soft_rst_i) begin
         z_nxt     = 12'h000;                              // [R14]
         pend_nxt  = 8'h00;
         fresh_nxt = 1'b0;
         lock_nxt  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         z_r     <= 12'h000;
         pend_r  <= 8'h00;
         fresh_r <= 1'b0;
         lock_r  <= 1'b0;
      end else begin
         z_r     <= z_nxt;
         pend_r  <= pend_nxt;
         fresh_r <= fresh_nxt;
         lock_r  <= lock_nxt;
      end
   end

   assign z_o      = z_r;
   assign fresh_o  = fresh_r;
   assign locked_o = lock_r;
endmodule

/* tb/acr_host_model.sv */
// host-side serial bus controller model, open-drain data line with pull-up
module acr_host_model (
   input  wire logic ref_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   ////////////////////////////////////////
   // four clocks per phase, well clear of the target's one-clock sampling
   task automatic hp();
      repeat (4) @(negedge ref_clk_i);
   endtask
   // start or repeated start; clock idles high between frames
   task automatic st();
      sda_o = 1'b1;
      hp();
      scl_o = 1'b1;
      hp();
      sda_o = 1'b0;
      hp();
      scl_o = 1'b0;
   endtask
   task automatic sp();
      sda_o = 1'b0;
      hp();
      scl_o = 1'b1;
      hp();
      sda_o = 1'b1;
      hp();
   endtask
   // byte msb first, then ninth bit; a released line reads back the target
   task automatic bx(input logic [7:0] d, input logic a, output logic [7:0] q,
                     output logic k);
      logic [8:0] v;
      logic [8:0] r;
      v = {d, a};
      for (int i = 8; i >= 0; i--) begin
         sda_o = v[i];
         hp();
         scl_o = 1'b1;
         hp();
         r[i] = sda_i;
         scl_o = 1'b0;
      end
      q = r[8:1];
      k = r[0];
   endtask
endmodule

/* tb/acr_regs_test.sv */
// self-checking bench of the accel register bank
module acr_regs_test
   import acr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        zv = 1'b0, sig = 1'b0, slp = 1'b0;
   logic [11:0] zf = 12'h000, zu = 12'h000;
   logic [2:0]  ax = 3'h0, ng = 3'h0, bw, sen;
   logic        scl, hsda, sdo, sda_oe_o, sus, lp, unf, fen;
   logic [3:0]  doze;
   acr_span_t   span;
   int          failures = 0, n_checks = 0;
   // pull-up: line low only while someone pulls it
   wire sda = hsda & (~sda_oe_o | sdo);
   always #12.5 ref_clk_i = ~ref_clk_i;
   acr_host_model h (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
   acr_regs DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sdo), .sda_oe_o(sda_oe_o), .z_valid_i(zv), .z_filt_i(zf), .z_unfilt_i(zu),
      .sig_motion_i(sig), .slope_i(slp), .slope_axis_i(ax), .slope_neg_i(ng),
      .span_o(span), .bw_step_o(bw), .suspend_o(sus), .reduced_power_enable_o(lp),
      .doze_duration_code_o(doze), .unfiltered_o(unf), .slope_irq_enable_o(sen),
      .fresh_sample_irq_enable_o(fen));
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       k;
      h.st();
      h.bx(8'h30, 1'b1, q, k);
      h.bx(a, 1'b1, q, k);
      h.bx(d, 1'b1, q, k);
      h.sp();
   endtask
   // pointer write, repeated start, one or two bytes back
   task automatic rd(input logic [7:0] a, input logic two, output logic [7:0] q0,
                     output logic [7:0] q1);
      logic k;
      h.st();
      h.bx(8'h30, 1'b1, q0, k);
      h.bx(a, 1'b1, q0, k);
      h.st();
      h.bx(8'h31, 1'b1, q0, k);
      h.bx(8'hFF, ~two, q0, k);
      if (two) h.bx(8'hFF, 1'b1, q1, k);
      h.sp();
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q, q1;
      rd(a, 1'b0, q, q1);
      chk(q, e);
   endtask
   task automatic wc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      wr(a, d);
      rc(a, e);
   endtask
   task automatic ev(input logic s, input logic m, input logic [2:0] x, input logic [2:0] n);
      @(negedge ref_clk_i);
      {sig, slp, ax, ng} = {s, m, x, n};
      @(negedge ref_clk_i);
      {sig, slp} = 2'b00;
   endtask
   task automatic zp(input logic [11:0] f, input logic [11:0] u);
      @(negedge ref_clk_i);
      {zv, zf, zu} = {1'b1, f, u};
      @(negedge ref_clk_i);
      zv = 1'b0;
   endtask
   ////////////////////////////////////////
   initial begin
      logic [7:0] a, b;
      repeat (4) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      chk(8'(span), 8'(ACR_SPAN_2G));
      chk({5'h0, bw}, 8'h07);
      rc(8'h0F, 8'h03);
      rc(8'h10, 8'h1F);
      rc(8'h11, 8'h00);
      rc(8'h13, 8'h00);
      rc(8'h16, 8'h00);
      rc(8'h17, 8'h00);
      wc(8'h0F, 8'hF5, 8'h05);
      chk(8'(span), 8'(ACR_SPAN_4G));
      wc(8'h0F, 8'h08, 8'h08);
      chk(8'(span), 8'(ACR_SPAN_8G));
      wc(8'h0F, 8'h07, 8'h07);
      chk(8'(span), 8'(ACR_SPAN_UNDEF));
      wc(8'h10, 8'hE9, 8'h09);
      chk({5'h0, bw}, 8'h01);
      wr(8'h10, 8'h08);
      chk({5'h0, bw}, 8'h00);
      wr(8'h10, 8'h0F);
      chk({5'h0, bw}, 8'h07);
      wc(8'h11, 8'hFF, 8'hDE);
      chk({sus, lp, 2'b00, doze}, 8'hCF);
      wc(8'h13, 8'hFF, 8'hC0);
      chk(8'(unf), 8'h01);
      wc(8'h16, 8'hFF, 8'h07);
      chk({5'h0, sen}, 8'h07);
      wc(8'h17, 8'hFF, 8'h10);
      chk(8'(fen), 8'h01);
      wc(8'h09, 8'hFF, 8'h00);
      rc(8'h30, 8'h00);
      ev(1'b1, 1'b1, 3'b101, 3'b100);
      rc(8'h0B, 8'h45);
      rc(8'h09, 8'h05);
      wr(8'h13, 8'h00);
      zp(12'hABC, 12'h123);
      rc(8'h0A, 8'h80);
      rd(8'h06, 1'b1, a, b);
      chk(a, 8'hC1);
      chk(b, 8'hAB);
      rc(8'h06, 8'hC0);
      zp(12'h456, 12'h000);
      rc(8'h07, 8'hAB);
      rc(8'h07, 8'h45);
      wr(8'h13, 8'h80);
      zp(12'h000, 12'h789);
      rc(8'h07, 8'h78);
      wr(8'h14, 8'hB6);
      rc(8'h0F, 8'h03);
      rc(8'h16, 8'h00);
      rc(8'h07, 8'h00);
      wr(8'h13, 8'h40);
      rc(8'h06, 8'h00);
      zp(12'hDEF, 12'h000);
      rc(8'h07, 8'hDE);
      finish_test();
   end
   // whole run needs well under half of this span
   initial begin
      #2_000_000;
      failures++;
      finish_test();
   end
endmodule
